// ===== verilog/slc_serdes_ctl.sv
// Purpose: Lock, sleep, output-enable and loopback control for a 16-bit embedded-clock serial link
// Assumes: hclk at 50 MHz; link_clock and serial_in come from the remote end and are resynchronised here
// Notes: Control bits live in a register reached over AHB-Lite; the slave has no wait states
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "slc_map.svh"

// Overview of operation
// - two consecutive missed clock edges drop lock
// - after loss, hunt for edge and relock automatically
// - receive data valid only while lock low
// - several candidate clock positions per word block lock
// - single candidate again lets receiver lock
// - receiver sleep stops PLL, outputs high impedance
// - leaving receiver sleep enters initialization
// - transmitter sleep stops PLL, serial output off except in line loopback
// - transmitter PLL locks word clock before initialization
// - receive enable low floats data and strobe
// - transmit enable low floats serial output
// - line loopback routes serial input to both outputs
// - local loopback returns parallel input, serial off
// - data and strobe float until transmission seen and locked
// - disconnected input floats data and strobe and drops lock
// - word is start one, sixteen bits, stop zero
// - alignment word is eight ones then eight zeros
// - alignment stream locks after 150 word cycles
// - request held six words sends alignment words
module slc_serdes_ctl #(
  parameter int ACQ_WORDS = `SLC_ACQ_WORDS,     // Good words needed before lock
  parameter int ALIGN_WORDS = `SLC_ALIGN_WORDS, // Request words before alignment is sent
  parameter int PLL_EDGES = `SLC_PLL_EDGES      // Local clock edges for a PLL to settle
) (
  input wire logic hclk,                   // Bus and core clock
  input wire logic hresetn,                // Asynchronous reset, active low
  input wire logic hsel,                   // Slave select
  input wire logic [31:0] haddr,           // Byte address
  input wire logic [1:0] htrans,           // Transfer type
  input wire logic hwrite,                 // Write when high
  input wire logic [2:0] hsize,            // Transfer size
  input wire logic [31:0] hwdata,          // Write data
  input wire logic hready,                 // Bus ready
  output logic hreadyout,                  // Slave ready
  output logic hresp,                      // Response, always OKAY
  output logic [31:0] hrdata,              // Read data
  input wire logic link_clock,             // Remote bit clock
  input wire logic serial_in,              // Remote serial data
  input wire logic rx_reference_clock,     // Receiver local reference
  input wire logic tx_word_clock,          // Transmitter local word clock
  input wire logic [15:0] tx_parallel_in,  // Word to send
  input wire logic tx_align_req,           // Alignment request
  output logic serial_out,                 // Serial data out
  output logic serial_out_oe,              // Serial output driven
  output logic serial_out_clock,           // Bit clock out
  output logic [15:0] rx_parallel_out,     // Received word
  output logic rx_data_oe,                 // Data and strobe driven
  output logic rx_word_strobe,             // Recovered word pulse
  output logic rx_lock_n,                  // Lock indicator, low when locked
  output logic rx_lock_oe,                 // Lock indicator driven
  output logic repeated_edge_pattern       // Ambiguous clock position seen
);
  localparam int BIT_DIV = `SLC_BIT_NS / `SLC_HCLK_NS;
  localparam int DISC_CYCLES = `SLC_DISC_NS / `SLC_HCLK_NS;
  localparam int WB = `SLC_WORD_BITS;
  localparam logic [4:0] LAST_BIT = 5'(WB - 1);

  // Bus slave state
  logic act_q;                   // Data phase pending
  logic wr_q;                    // Pending access is a write
  logic [7:0] addr_q;            // Pending offset
  logic [`SLC_CTRL_W-1:0] ctrl;  // Control register

  // Synchronisers: first stage feeds only the second
  logic lk_s1, lk_s2, lk_s3;
  logic si_s1, si_s2;
  logic rf_s1, rf_s2, rf_s3;
  logic tw_s1, tw_s2, tw_s3;

  // Transmit side
  slc_pkg::slc_tx_state_t tx_state;
  logic [3:0] div;               // Bit-time divider
  logic [4:0] tx_pos;            // Bit within outgoing word
  logic [WB-1:0] tx_shift;       // Outgoing frame, start bit first
  logic [7:0] tx_pll_cnt;        // Word clock edges seen
  logic [7:0] align_cnt;         // Words with request held

  // Receive side
  slc_pkg::slc_rx_state_t rx_state;
  logic [WB-1:0] win;            // Last eighteen bits received
  logic [4:0] span;              // Free-running bit slot
  logic [4:0] cand_cnt;          // Candidates in this span
  logic [4:0] cand_pos;          // Slot of last candidate
  logic [4:0] last_pos;          // Slot found in previous span
  logic [4:0] phase;             // Locked word boundary slot
  logic [7:0] good_cnt;          // Consistent spans so far
  logic [1:0] miss_cnt;          // Consecutive missed edges
  logic [7:0] rf_cnt;            // Reference edges seen
  logic [7:0] idle_cnt;          // Cycles since last link edge
  logic line_bit;                // Retimed bit for line loopback

  // Control bit decode
  wire rx_awake = ctrl[`SLC_RX_SLEEP_N_BIT];
  wire tx_awake = ctrl[`SLC_TX_SLEEP_N_BIT];
  wire rx_oe_en = ctrl[`SLC_RX_OE_BIT];
  wire tx_oe_en = ctrl[`SLC_TX_OE_BIT];
  wire line_loop = ctrl[`SLC_LINE_LOOP_BIT];
  wire local_loop = ctrl[`SLC_LOCAL_LOOP_BIT];

  // Bus decode
  wire take = hsel & htrans[1] & hready & (hsize == 3'b010);
  wire wr_ctrl = act_q & wr_q & (addr_q == `SLC_CTRL_ADDR);
  wire locked = (rx_state == slc_pkg::SLC_RX_LOCKED);
  wire [31:0] status_word = {26'h0000000, repeated_edge_pattern, tx_state, rx_state, locked};
  wire [31:0] read_mux = (addr_q == `SLC_CTRL_ADDR) ? {26'h0000000, ctrl} :
                         (addr_q == `SLC_STATUS_ADDR) ? status_word :
                         (addr_q == `SLC_RXDATA_ADDR) ? {16'h0000, rx_parallel_out} : 32'h00000000;
  assign hrdata = (act_q & ~wr_q) ? read_mux : 32'h00000000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Edge detection on resynchronised clocks
  wire link_tick = lk_s2 & ~lk_s3;
  wire rf_tick = rf_s2 & ~rf_s3;
  wire tw_tick = tw_s2 & ~tw_s3;

  // Transmit timing and word selection
  wire tx_tick = (div == 4'(BIT_DIV - 1));
  wire tx_word_end = tx_tick & (tx_pos == LAST_BIT);
  wire tx_framing = (tx_state == slc_pkg::SLC_TX_INIT) | (tx_state == slc_pkg::SLC_TX_RUN);
  wire send_align = (tx_state == slc_pkg::SLC_TX_INIT) | (align_cnt >= 8'(ALIGN_WORDS));
  wire [15:0] tx_word = send_align ? `SLC_ALIGN_WORD : tx_parallel_in;
  wire [WB-1:0] tx_frame = {1'b1, tx_word, 1'b0};

  // Receive bit source: own transmitter in local loopback, else the link
  wire rx_tick = local_loop ? (tx_tick & tx_framing) : link_tick;
  wire rx_bit = local_loop ? tx_shift[WB-1] : si_s2;
  wire [WB-1:0] next_win = {win[WB-2:0], rx_bit};
  wire cand_now = next_win[WB-1] & ~next_win[0];
  wire span_end = rx_tick & (span == LAST_BIT);
  wire [4:0] pos_now = cand_now ? span : cand_pos;
  wire [4:0] cand_total = cand_cnt + 5'(cand_now);
  wire span_good = (cand_total == 5'h01) & (pos_now == last_pos);
  wire lock_slot = rx_tick & (span == phase);
  wire disc = ~local_loop & (idle_cnt == 8'(DISC_CYCLES));
  wire lose = lock_slot & ~cand_now & (miss_cnt == 2'(`SLC_MISS_LIMIT - 1));

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      act_q <= take;
      wr_q <= hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `SLC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= hwdata[`SLC_CTRL_W-1:0];
    end
  end

  // Two-stage synchronisers plus an edge stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {lk_s1, lk_s2, lk_s3, si_s1, si_s2} <= 5'h00;
      {rf_s1, rf_s2, rf_s3, tw_s1, tw_s2, tw_s3} <= 6'h00;
    end else begin
      {lk_s1, lk_s2, lk_s3} <= {link_clock, lk_s1, lk_s2};
      {si_s1, si_s2} <= {serial_in, si_s1};
      {rf_s1, rf_s2, rf_s3} <= {rx_reference_clock, rf_s1, rf_s2};
      {tw_s1, tw_s2, tw_s3} <= {tx_word_clock, tw_s1, tw_s2};
    end
  end

  // Bit-time divider; the outgoing clock rises mid-bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div <= 4'h0;
    end else begin
      div <= tx_tick ? 4'h0 : div + 4'h1;
    end
  end

  // Transmit state: sleep, PLL settle on word clock, one init word, run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_state <= slc_pkg::SLC_TX_SLEEP;
      tx_pll_cnt <= 8'h00;
    end else if (!tx_awake) begin
      tx_state <= slc_pkg::SLC_TX_SLEEP;
      tx_pll_cnt <= 8'h00;
    end else begin
      unique case (tx_state)
        slc_pkg::SLC_TX_SLEEP: tx_state <= slc_pkg::SLC_TX_PLL;
        slc_pkg::SLC_TX_PLL: begin
          // Word clock must tick before anything is framed
          if (tw_tick && tx_pll_cnt != 8'(PLL_EDGES)) begin
            tx_pll_cnt <= tx_pll_cnt + 8'h01;
          end
          if (tx_pll_cnt == 8'(PLL_EDGES) && tx_word_end) begin
            tx_state <= slc_pkg::SLC_TX_INIT;
          end
        end
        slc_pkg::SLC_TX_INIT: begin
          if (tx_word_end) begin
            tx_state <= slc_pkg::SLC_TX_RUN;
          end
        end
        slc_pkg::SLC_TX_RUN: tx_state <= slc_pkg::SLC_TX_RUN;
      endcase
    end
  end

  // Serialiser: load a frame at each word end, shift one bit per bit time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pos <= 5'h00;
      tx_shift <= {WB{1'b0}};
      align_cnt <= 8'h00;
    end else if (tx_tick) begin
      tx_pos <= tx_word_end ? 5'h00 : tx_pos + 5'h01;
      tx_shift <= tx_word_end ? tx_frame : {tx_shift[WB-2:0], 1'b0};
      if (tx_word_end) begin
        // Request counted per word; after it drops, one more alignment word is loaded at the word end that clears the count
        align_cnt <= !tx_align_req ? 8'h00 :
                     (align_cnt >= 8'(ALIGN_WORDS)) ? align_cnt : align_cnt + 8'h01;
      end
    end
  end

  // Serial output: loopback source, gating by enable, sleep and local loopback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out <= 1'b0;
      serial_out_clock <= 1'b0;
      serial_out_oe <= 1'b0;
      line_bit <= 1'b0;
    end else begin
      if (link_tick) begin
        line_bit <= si_s2;
      end
      serial_out <= line_loop ? line_bit : tx_shift[WB-1];
      serial_out_clock <= line_loop ? lk_s3 : (div >= 4'(BIT_DIV / 2));
      // Enable only gates the pin, so re-raising it resumes the same stream
      serial_out_oe <= tx_oe_en & ~local_loop &
                       (line_loop ? rx_awake : tx_framing);
    end
  end

  // Idle monitor for a disconnected input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt <= 8'h00;
    end else if (link_tick) begin
      idle_cnt <= 8'h00;
    end else if (!disc) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // Receive window and free-running slot counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      win <= {WB{1'b0}};
      span <= 5'h00;
    end else if (rx_tick) begin
      win <= next_win;
      span <= (span == LAST_BIT) ? 5'h00 : span + 5'h01;
    end
  end

  // Candidate clock positions within each span
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cand_cnt <= 5'h00;
      cand_pos <= 5'h00;
      last_pos <= 5'h00;
    end else if (rx_tick) begin
      cand_pos <= pos_now;
      cand_cnt <= span_end ? 5'h00 : cand_total;
      if (span_end) begin
        last_pos <= pos_now;
      end
    end
  end

  // Receive state machine
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= slc_pkg::SLC_RX_SLEEP;
      rf_cnt <= 8'h00;
      good_cnt <= 8'h00;
      miss_cnt <= 2'h0;
      phase <= 5'h00;
      repeated_edge_pattern <= 1'b0;
    end else if (!rx_awake) begin
      rx_state <= slc_pkg::SLC_RX_SLEEP;
      rf_cnt <= 8'h00;
      repeated_edge_pattern <= 1'b0;
    end else begin
      unique case (rx_state)
        slc_pkg::SLC_RX_SLEEP: rx_state <= slc_pkg::SLC_RX_INIT;
        slc_pkg::SLC_RX_INIT: begin
          // Without a running reference the receiver never leaves here
          if (rf_tick) begin
            rf_cnt <= rf_cnt + 8'h01;
          end
          if (rf_cnt == 8'(PLL_EDGES)) begin
            rx_state <= slc_pkg::SLC_RX_HUNT;
            good_cnt <= 8'h00;
          end
        end
        slc_pkg::SLC_RX_HUNT: begin
          if (span_end) begin
            repeated_edge_pattern <= (cand_total > 5'h01);
            good_cnt <= span_good ? good_cnt + 8'h01 : 8'h00;
            if (span_good && good_cnt == 8'(ACQ_WORDS - 1)) begin
              rx_state <= slc_pkg::SLC_RX_LOCKED;
              phase <= pos_now;
              miss_cnt <= 2'h0;
            end
          end
        end
        slc_pkg::SLC_RX_LOCKED: begin
          repeated_edge_pattern <= 1'b0;
          if (lose || disc) begin
            rx_state <= slc_pkg::SLC_RX_HUNT;
            good_cnt <= 8'h00;
          end else if (lock_slot) begin
            miss_cnt <= cand_now ? 2'h0 : miss_cnt + 2'h1;
          end
        end
      endcase
    end
  end

  // Parallel word and recovered strobe at each locked boundary
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_parallel_out <= 16'h0000;
      rx_word_strobe <= 1'b0;
    end else begin
      // A sleep request wins over a word boundary in the same cycle
      rx_word_strobe <= locked & rx_awake & lock_slot & cand_now;
      if (locked && rx_awake && lock_slot && cand_now) begin
        rx_parallel_out <= next_win[WB-2:1];
      end
    end
  end

  // Lock indicator and pin drives follow the state directly
  assign rx_lock_n = ~locked;
  assign rx_lock_oe = rx_awake;
  assign rx_data_oe = rx_awake & rx_oe_en & locked;
endmodule

// ===== verilog/slc_map.svh
// Purpose: Offsets, field positions, reset values and timing figures of the link-state controller
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, one aligned word per register
// Notes: Times are in nanoseconds; cycle counts are derived in the module
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH

`define SLC_CTRL_ADDR 8'h00
`define SLC_STATUS_ADDR 8'h04
`define SLC_RXDATA_ADDR 8'h08

`define SLC_CTRL_W 6
`define SLC_CTRL_RESET 6'h0f
`define SLC_RX_SLEEP_N_BIT 0
`define SLC_TX_SLEEP_N_BIT 1
`define SLC_RX_OE_BIT 2
`define SLC_TX_OE_BIT 3
`define SLC_LINE_LOOP_BIT 4
`define SLC_LOCAL_LOOP_BIT 5

`define SLC_HCLK_NS 20
`define SLC_BIT_NS 160
`define SLC_DISC_NS 1600
`define SLC_WORD_BITS 18
`define SLC_ACQ_WORDS 150
`define SLC_ALIGN_WORDS 6
`define SLC_MISS_LIMIT 2
`define SLC_PLL_EDGES 16
`define SLC_ALIGN_WORD 16'hff00

`endif

// ===== verilog/slc_pkg.sv
// Purpose: Types shared by the link-state controller
// Assumes: Nothing beyond SystemVerilog packages
// Notes: State codes are written out so status reads are stable
package slc_pkg;
  typedef enum logic [1:0] {
    SLC_RX_SLEEP = 2'b00,
    SLC_RX_INIT = 2'b01,
    SLC_RX_HUNT = 2'b10,
    SLC_RX_LOCKED = 2'b11
  } slc_rx_state_t;

  typedef enum logic [1:0] {
    SLC_TX_SLEEP = 2'b00,
    SLC_TX_PLL = 2'b01,
    SLC_TX_INIT = 2'b10,
    SLC_TX_RUN = 2'b11
  } slc_tx_state_t;
endpackage

// ===== sim/slc_remote_end.sv
// Purpose: Remote serializer model feeding the link side of the controller
// Assumes: 160 ns bit period; data changes half a bit before each clock rise
// Notes: Clock stands still while idle; the released line then toggles as noise
`timescale 1ns/1ps
module slc_remote_end (
  input wire logic run,         // Send frames while high
  input wire logic [1:0] mode,  // 0 alignment, 1 data word, 2 repeating pattern
  input wire logic [15:0] word, // Data word for mode 1
  output logic link_clock,      // Bit clock, rises mid-bit
  output logic serial_in        // Serial data
);
  logic [17:0] frame; // Frame now on the wire
  // Frame generator; a disconnected line must not hold its last level
  initial begin
    link_clock = 1'b0;
    serial_in = 1'b0;
    forever begin
      if (!run) begin
        #80 serial_in = ~serial_in;
      end else begin
        // Start one, data MSB first, stop zero; 5555 gives many 0-1 candidates
        frame = {1'b1, (mode == 2'd0) ? 16'hff00 : (mode == 2'd1) ? word : 16'h5555, 1'b0};
        for (int i = 17; i >= 0; i--) begin
          serial_in = frame[i];
          #80 link_clock = 1'b1;
          #80 link_clock = 1'b0;
        end
      end
    end
  end
endmodule

// ===== sim/slc_serdes_ctl_monitor.sv
// Purpose: Port-level checks of the link-state controller
// Assumes: Zero-wait bus slave; control word mirrored from bus writes
// Notes: Mirror lands on the same edge as the real control register
`timescale 1ns/1ps
module slc_serdes_ctl_monitor (
  input wire logic hclk,                   // Core clock
  input wire logic hresetn,                // Reset, active low
  input wire logic hsel,                   // Slave select
  input wire logic [31:0] haddr,           // Byte address
  input wire logic [1:0] htrans,           // Transfer type
  input wire logic hwrite,                 // Write flag
  input wire logic [2:0] hsize,            // Transfer size
  input wire logic [31:0] hwdata,          // Write data
  input wire logic hready,                 // Bus ready
  input wire logic link_clock,             // Remote bit clock
  input wire logic serial_out_oe,          // Serial output driven
  input wire logic [15:0] rx_parallel_out, // Received word
  input wire logic rx_data_oe,             // Data and strobe driven
  input wire logic rx_word_strobe,         // New word pulse
  input wire logic rx_lock_n,              // Low when locked
  input wire logic rx_lock_oe              // Lock pin driven
);
  logic wr_pend; // Control write in its data phase
  logic [5:0] ctl; // Control word mirror
  logic [7:0] idle; // Cycles with the link clock still
  logic lc_q; // Link clock one cycle ago
  wire logic take = hsel && htrans[1] && hready && hsize == 3'b010; // Word transfer accepted
  // Mirror control writes and time link silence; counter saturates so it never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      ctl <= 6'h0f;
      idle <= 8'h00;
      lc_q <= 1'b0;
    end else begin
      wr_pend <= take && hwrite && haddr[7:0] == 8'h00;
      if (wr_pend) begin
        ctl <= hwdata[5:0];
      end
      lc_q <= link_clock;
      idle <= (link_clock != lc_q) ? 8'h00 : (idle == 8'hff) ? idle : idle + 8'h01;
    end
  end
  default clocking mon_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_LOCK_OE: assert property (rx_lock_oe == ctl[0])
    else $error("lock pin drive does not follow receiver sleep");
  AST_RX_SLEEP: assert property ((!ctl[0]) [*2] |-> rx_lock_n)
    else $error("sleeping receiver reports lock");
  AST_WAKE_INIT: assert property ($rose(rx_lock_oe) |-> rx_lock_n [*8])
    else $error("receiver locked straight out of sleep");
  AST_DATA_OE: assert property (rx_data_oe |-> ctl[2] && !rx_lock_n)
    else $error("receive data driven while disabled or unlocked");
  AST_STROBE_LOCKED: assert property (rx_word_strobe |-> !rx_lock_n)
    else $error("word strobe without lock");
  AST_DATA_HOLD: assert property ($changed(rx_parallel_out) |-> rx_word_strobe)
    else $error("receive word changed without strobe");
  AST_TX_OE_EN: assert property (serial_out_oe |-> $past(ctl[3]))
    else $error("serial output driven while disabled");
  AST_TX_LOCAL: assert property (serial_out_oe |-> !$past(ctl[5]))
    else $error("serial output driven in local loopback");
  AST_TX_SLEEP: assert property ((!ctl[1] && !ctl[4]) [*3] |-> !serial_out_oe)
    else $error("serial output driven while transmitter sleeps");
  AST_FAILSAFE: assert property (idle == 8'd100 && !ctl[5] |-> rx_lock_n && !rx_data_oe)
    else $error("lock kept on a silent link");
endmodule

bind slc_serdes_ctl slc_serdes_ctl_monitor slc_serdes_ctl_monitor_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .link_clock(link_clock), .serial_out_oe(serial_out_oe), .rx_parallel_out(rx_parallel_out),
  .rx_data_oe(rx_data_oe), .rx_word_strobe(rx_word_strobe), .rx_lock_n(rx_lock_n), .rx_lock_oe(rx_lock_oe));

// ===== sim/test_slc_serdes_ctl.sv
// Purpose: Self-checking bench for the link-state controller
// Assumes: Zero-wait bus slave; lock and PLL counts shortened by parameters
// Notes: Expected words are the ones the remote model or the bench sends
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_slc_serdes_ctl;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_align_req = 1'b0, run = 1'b0; // Driven controls
  logic [1:0] htrans = 2'b00, mode = 2'd0; // Transfer type, model mode
  logic [2:0] hsize = 3'b010; // Always whole words
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd; // Bus data and last read
  logic [15:0] tx_parallel_in = 16'h0, word = 16'ha5c3, rx_parallel_out; // Parallel words
  logic hclk, hready, hreadyout, hresp, link_clock, serial_in, rx_reference_clock, tx_word_clock; // Clocks, bus
  logic serial_out, serial_out_oe, serial_out_clock, rx_data_oe, rx_word_strobe, rx_lock_n, rx_lock_oe, rep; // Outputs
  int errors = 0; // Mismatches
  int check_count = 0; // Comparisons
  assign hready = hreadyout; // One slave drives bus ready
  slc_serdes_ctl #(.ACQ_WORDS(4), .PLL_EDGES(2)) slc_serdes_ctl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clock(link_clock), .serial_in(serial_in),
    .rx_reference_clock(rx_reference_clock), .tx_word_clock(tx_word_clock), .tx_parallel_in(tx_parallel_in),
    .tx_align_req(tx_align_req), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .serial_out_clock(serial_out_clock), .rx_parallel_out(rx_parallel_out), .rx_data_oe(rx_data_oe),
    .rx_word_strobe(rx_word_strobe), .rx_lock_n(rx_lock_n), .rx_lock_oe(rx_lock_oe), .repeated_edge_pattern(rep));
  slc_remote_end slc_remote_end_inst (.run(run), .mode(mode), .word(word), .link_clock(link_clock),
    .serial_in(serial_in));
  // Clocks; the reference runs from time zero so the receiver can always lock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    rx_reference_clock = 1'b0;
    forever #30 rx_reference_clock = ~rx_reference_clock;
  end
  initial begin
    tx_word_clock = 1'b0;
    forever #72 tx_word_clock = ~tx_word_clock;
  end
  // Counts, verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One single-word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    for (n = 0; hreadyout !== 1'b1 && n < 50; n++) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    for (n = n; hreadyout !== 1'b1 && n < 50; n++) @(posedge hclk);
    rd = hrdata;
    if (n >= 50) begin
      errors++;
      report_and_stop();
    end
  endtask
  // Bounded wait: 0 lock level, 1 strobe with word, 2 serial drive level
  task automatic wait_until(input int sel, input logic [15:0] exp, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge hclk);
      #1;
      if (sel == 0 && rx_lock_n === exp[0]) break;
      if (sel == 1 && rx_word_strobe === 1'b1 && rx_parallel_out === exp) break;
      if (sel == 2 && serial_out_oe === exp[0]) break;
    end
    `CHK(n < lim, 1'b1)
    if (n >= lim) report_and_stop();
  endtask
  task automatic t_reset();
    `CHK({rx_lock_n, rx_data_oe}, 2'b10)
    `CHK({hreadyout, hresp}, 2'b10) // Zero-wait slave, OKAY response
    bus(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000000f)
    bus(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h00000000)
    $display("t_reset done");
  endtask
  task automatic t_tx();
    wait_until(2, 16'h1, 1000);
    bus(1'b1, 8'h00, 32'h07);
    wait_until(2, 16'h0, 5);
    bus(1'b1, 8'h00, 32'h0f);
    wait_until(2, 16'h1, 5);
    bus(1'b1, 8'h00, 32'h0d);
    wait_until(2, 16'h0, 5);
    bus(1'b1, 8'h00, 32'h0f);
    repeat (3) @(posedge hclk);
    `CHK(serial_out_oe, 1'b0)
    wait_until(2, 16'h1, 1000);
    $display("t_tx done");
  endtask
  task automatic t_lock();
    run <= 1'b1;
    wait_until(1, 16'hff00, 3000);
    `CHK(rx_data_oe, 1'b1)
    mode <= 2'd1;
    wait_until(1, 16'ha5c3, 1000);
    bus(1'b0, 8'h04, 32'h0);
    `CHK(rd[4:0], 5'h1f)
    $display("t_lock done");
  endtask
  task automatic t_loss();
    run <= 1'b0;
    wait_until(0, 16'h1, 300);
    `CHK(rx_data_oe, 1'b0)
    mode <= 2'd2;
    run <= 1'b1;
    repeat (1500) @(posedge hclk);
    `CHK({rx_lock_n, rep}, 2'b11)
    // A repeated data word is itself ambiguous, so relock on alignment words
    mode <= 2'd0;
    wait_until(1, 16'hff00, 3000);
    mode <= 2'd1; // Data resent once lock is back
    wait_until(1, 16'ha5c3, 1000);
    $display("t_loss done");
  endtask
  task automatic t_rx_ctl();
    bus(1'b1, 8'h00, 32'h0b);
    repeat (3) @(posedge hclk);
    `CHK({rx_data_oe, rx_lock_n}, 2'b00)
    bus(1'b1, 8'h00, 32'h0f);
    repeat (3) @(posedge hclk);
    `CHK(rx_data_oe, 1'b1)
    bus(1'b1, 8'h00, 32'h0e);
    repeat (3) @(posedge hclk);
    `CHK({rx_lock_oe, rx_lock_n, rx_data_oe}, 3'b010)
    bus(1'b1, 8'h00, 32'h0f);
    repeat (3) @(posedge hclk);
    `CHK(rx_lock_n, 1'b1)
    mode <= 2'd0;
    wait_until(1, 16'hff00, 3000);
    mode <= 2'd1;
    wait_until(1, 16'ha5c3, 1000);
    $display("t_rx_ctl done");
  endtask
  task automatic t_loop();
    logic [17:0] sh;
    logic pc;
    int k;
    bus(1'b1, 8'h00, 32'h1f);
    wait_until(2, 16'h1, 5);
    wait_until(1, 16'ha5c3, 3000);
    sh = 18'h00000;
    pc = 1'b0;
    // Line loopback must copy the incoming frame onto the serial output
    for (k = 0; k < 1000 && sh !== {1'b1, 16'ha5c3, 1'b0}; k++) begin
      @(posedge hclk);
      #1;
      if (pc && !serial_out_clock) sh = {sh[16:0], serial_out};
      pc = serial_out_clock;
    end
    `CHK(sh, {1'b1, 16'ha5c3, 1'b0})
    bus(1'b1, 8'h00, 32'h2f);
    // A repeated data word never locks, so the own transmitter aligns first
    tx_parallel_in <= 16'h3c5a;
    tx_align_req <= 1'b1;
    wait_until(2, 16'h0, 5);
    wait_until(1, 16'hff00, 5000);
    @(posedge hclk);
    tx_align_req <= 1'b0;
    wait_until(1, 16'h3c5a, 1000);
    $display("t_loop done");
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_tx();
    t_lock();
    t_loss();
    t_rx_ctl();
    t_loop();
    report_and_stop();
  end
endmodule
